// ### pkg/jtp_pkg.sv
// Shared constants, state and selection types for the test access port
package jtp_pkg;
    // Instruction register
    localparam int          IR_W         = 3;
    localparam logic [2:0]  IR_CAPTURE   = 3'h1;
    localparam logic [2:0]  IR_EXTEST    = 3'h0;
    localparam logic [2:0]  IR_SAMPLE    = 3'h1;
    localparam logic [2:0]  IR_DEBUG     = 3'h2;
    localparam logic [2:0]  IR_BYPASS    = 3'h3;
    localparam logic [2:0]  IR_PROG      = 3'h4;
    localparam logic [2:0]  IR_BYPASS_B  = 3'h5;
    localparam logic [2:0]  IR_RESERVED  = 3'h6;
    localparam logic [2:0]  IR_BYPASS_C  = 3'h7;
    // Data register lengths
    localparam int          DEBUG_LEN    = 10;
    localparam int          PROG_LEN     = 3;
    // Consecutive high mode-select samples that always reach reset
    localparam int          TLR_HIGH_EDGES = 5;
    // Host test clock should stay at or below system clock over this ratio
    localparam int          TCK_RATIO    = 8;
    localparam int          SYNC_STAGES  = 2;
    localparam int          BUF_DEPTH    = 2;

    typedef enum logic [1:0] {
        SEL_BYPASS,
        SEL_DEBUG,
        SEL_PROG
    } jtp_sel_e;

    typedef enum logic [3:0] {
        ST_RESET,
        ST_IDLE,
        ST_SEL_DR,
        ST_CAP_DR,
        ST_SHIFT_DR,
        ST_EXIT1_DR,
        ST_PAUSE_DR,
        ST_EXIT2_DR,
        ST_UPD_DR,
        ST_SEL_IR,
        ST_CAP_IR,
        ST_SHIFT_IR,
        ST_EXIT1_IR,
        ST_PAUSE_IR,
        ST_EXIT2_IR,
        ST_UPD_IR
    } jtp_state_e;
endpackage : jtp_pkg

// ### pkg/jtp_stream_if.sv
// Valid/ready word stream between the port logic and its buffer
`timescale 1ns/1ps
interface jtp_stream_if #(
    parameter int W = 12
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : jtp_stream_if

// ### hw/jtp_sync.sv
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module jtp_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         srst,
    // Asynchronous in, synchronised out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (srst) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : jtp_sync

// ### hw/jtp_buf.sv
// Two-entry valid/ready buffer
`timescale 1ns/1ps
module jtp_buf #(
    parameter int W     = 12,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Fill and drain sides
    jtp_stream_if.snk in_s,
    jtp_stream_if.src out_s
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0]  mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    wire           push = in_s.valid && in_s.ready;
    wire           pop  = out_s.valid && out_s.ready;

    if (DEPTH != 2) begin : g_chk
        $error("jtp_buf: depth must be 2");
    end

    assign in_s.ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_s.valid = (cnt_q != '0);
    assign out_s.data  = mem_q[rp_q];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q] <= in_s.data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            wp_q  <= push ? wp_q + 1'b1 : wp_q;
            rp_q  <= pop ? rp_q + 1'b1 : rp_q;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : jtp_buf

// ### hw/jtp_tap.sv
// Test access port controller sampled on the system clock
`timescale 1ns/1ps
module jtp_tap
    import jtp_pkg::*;
#(
    parameter int DR_W = DEBUG_LEN
) (
    // System clock and reset
    input  wire logic            CLK,
    input  wire logic            SRST,
    // Test port pins
    input  wire logic            TCK,
    input  wire logic            TMS,
    input  wire logic            TDI,
    output logic                 TDO,
    output logic                 TDO_OE,
    // Port enable and pull-up control
    input  wire logic            TAP_EN,
    output logic                 PULLUP_EN,
    // Current instruction
    output logic [IR_W-1:0]      PARALLEL_INSTRUCTION_BITS,
    // Data words shifted in, toward the system
    output logic                 DR_OUT_VALID,
    input  wire logic            DR_OUT_READY,
    output logic [1:0]           DR_OUT_SEL,
    output logic [DR_W-1:0]      DR_OUT_DATA,
    output logic                 DR_BUF_READY,
    // Parallel word loaded for shifting out
    input  wire logic [DR_W-1:0] DR_IN_DATA
);
    ////////////////////////////////////////////////////////////////////////////
    if (DR_W < DEBUG_LEN || DR_W < PROG_LEN) begin : g_chk
        $error("jtp_tap: DR_W too small for the data registers");
    end

    // Next controller state from the sampled mode select
    function automatic jtp_state_e next_state(jtp_state_e s, logic tms);
        case (s)
            ST_RESET:    next_state = tms ? ST_RESET   : ST_IDLE;
            ST_IDLE:     next_state = tms ? ST_SEL_DR  : ST_IDLE;
            ST_SEL_DR:   next_state = tms ? ST_SEL_IR  : ST_CAP_DR;
            ST_CAP_DR:   next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: next_state = tms ? ST_UPD_DR  : ST_PAUSE_DR;
            ST_PAUSE_DR: next_state = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: next_state = tms ? ST_UPD_DR  : ST_SHIFT_DR;
            ST_UPD_DR:   next_state = tms ? ST_SEL_DR  : ST_IDLE;
            ST_SEL_IR:   next_state = tms ? ST_RESET   : ST_CAP_IR;
            ST_CAP_IR:   next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: next_state = tms ? ST_UPD_IR  : ST_PAUSE_IR;
            ST_PAUSE_IR: next_state = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: next_state = tms ? ST_UPD_IR  : ST_SHIFT_IR;
            ST_UPD_IR:   next_state = tms ? ST_SEL_DR  : ST_IDLE;
            default:     next_state = ST_RESET;
        endcase
    endfunction : next_state

    // Data register selection for a newly loaded instruction
    function automatic jtp_sel_e decode_sel(logic [IR_W-1:0] ir, jtp_sel_e cur);
        case (ir)
            IR_DEBUG:    decode_sel = SEL_DEBUG;
            IR_PROG:     decode_sel = SEL_PROG;
            IR_BYPASS,
            IR_BYPASS_B,
            IR_BYPASS_C: decode_sel = SEL_BYPASS;
            default:     decode_sel = cur;
        endcase
    endfunction : decode_sel

    ////////////////////////////////////////////////////////////////////////////
    // Pin sampling; the edges of the test clock become one-cycle enables
    logic [2:0] pin_s;
    logic       tck_d1_q;

    jtp_sync #(.W(3)) u_sync (
        .clk  (CLK),
        .srst (SRST),
        .d    ({TCK, TMS, TDI}),
        .q    (pin_s)
    );

    wire tck_s    = pin_s[2];
    wire tms_s    = pin_s[1];
    wire tdi_s    = pin_s[0];
    // TMS and TDI ride the same two stages, so they stay aligned with TCK
    wire tck_rise = tck_s && !tck_d1_q;
    wire tck_fall = !tck_s && tck_d1_q;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            tck_d1_q <= 1'b0;
        end else begin
            tck_d1_q <= tck_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Controller state
    jtp_state_e st_q;
    wire        in_shift_ir = (st_q == ST_SHIFT_IR);
    wire        in_shift_dr = (st_q == ST_SHIFT_DR);

    always_ff @(posedge CLK) begin
        if (SRST) begin
            st_q <= ST_RESET;
        end else if (tck_rise) begin
            st_q <= next_state(st_q, tms_s);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Instruction path
    logic [IR_W-1:0] ir_sh_q;
    logic [IR_W-1:0] ir_q;
    jtp_sel_e        sel_q;

    // Apart from the bypass reload in Test-Logic-Reset, nothing moves between test-clock edges, so a stopped clock holds all
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ir_sh_q <= IR_CAPTURE;
        end else if (tck_rise && st_q == ST_CAP_IR) begin
            ir_sh_q <= IR_CAPTURE;
        end else if (tck_rise && in_shift_ir) begin
            ir_sh_q <= {tdi_s, ir_sh_q[IR_W-1:1]};
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            ir_q  <= IR_BYPASS;
            sel_q <= SEL_BYPASS;
        end else if (st_q == ST_RESET) begin
            ir_q  <= IR_BYPASS;
            sel_q <= SEL_BYPASS;
        end else if (tck_fall && st_q == ST_UPD_IR) begin
            ir_q  <= ir_sh_q;
            sel_q <= decode_sel(ir_sh_q, sel_q);
        end
    end

    assign PARALLEL_INSTRUCTION_BITS = ir_q;

    ////////////////////////////////////////////////////////////////////////////
    // Data path: bypass cell and the shared data shift register
    logic            byp_q;
    logic [DR_W-1:0] dr_sh_q;
    logic [DR_W-1:0] dr_shifted;
    logic [DR_W-1:0] dr_mask;
    wire             sel_byp = (sel_q == SEL_BYPASS);
    wire             dr_upd  = tck_fall && (st_q == ST_UPD_DR) && !sel_byp;

    // Shift right with the new bit landing at the top of the active length
    always_comb begin
        dr_mask    = (sel_q == SEL_PROG) ? DR_W'((1 << PROG_LEN) - 1)
                                         : DR_W'((1 << DEBUG_LEN) - 1);
        dr_shifted = dr_sh_q >> 1;
        if (sel_q == SEL_PROG) begin
            dr_shifted[PROG_LEN-1] = tdi_s;
        end else begin
            dr_shifted[DEBUG_LEN-1] = tdi_s;
        end
        dr_shifted = dr_shifted & dr_mask;
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            byp_q <= 1'b0;
        end else if (tck_rise && st_q == ST_CAP_DR) begin
            byp_q <= 1'b0;
        end else if (tck_rise && in_shift_dr && sel_byp) begin
            byp_q <= tdi_s;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            dr_sh_q <= '0;
        end else if (tck_rise && in_shift_dr && !sel_byp) begin
            dr_sh_q <= dr_shifted;
        end else if (dr_upd) begin
            dr_sh_q <= DR_IN_DATA & dr_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Captured words go to the system through a two-entry buffer.
    // The host cannot be stalled, so a word offered while DR_BUF_READY is
    // low is lost; the system must drain before the next Update-DR.
    jtp_stream_if #(.W(2 + DR_W)) fill_if ();
    jtp_stream_if #(.W(2 + DR_W)) drain_if ();

    assign fill_if.valid  = dr_upd;
    assign fill_if.data   = {sel_q, dr_sh_q};
    assign drain_if.ready = DR_OUT_READY;

    jtp_buf #(.W(2 + DR_W), .DEPTH(BUF_DEPTH)) u_buf (
        .clk   (CLK),
        .srst  (SRST),
        .in_s  (fill_if),
        .out_s (drain_if)
    );

    assign DR_OUT_VALID = drain_if.valid;
    assign DR_OUT_SEL   = drain_if.data[DR_W +: 2];
    assign DR_OUT_DATA  = drain_if.data[DR_W-1:0];
    assign DR_BUF_READY = fill_if.ready;

    ////////////////////////////////////////////////////////////////////////////
    // Serial output, updated on the falling edge only
    wire tdo_bit = in_shift_ir ? ir_sh_q[0] : (sel_byp ? byp_q : dr_sh_q[0]);

    always_ff @(posedge CLK) begin
        if (SRST) begin
            TDO    <= 1'b1;
            TDO_OE <= 1'b0;
        end else if (tck_fall) begin
            TDO    <= (in_shift_ir || in_shift_dr) ? tdo_bit : 1'b1;
            TDO_OE <= in_shift_ir || in_shift_dr;
        end
    end

    // Pull-ups follow the port-enable bit
    always_ff @(posedge CLK) begin
        if (SRST) begin
            PULLUP_EN <= 1'b0;
        end else begin
            PULLUP_EN <= TAP_EN;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    logic [2:0] hi_cnt_q;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            hi_cnt_q <= '0;
        end else if (tck_rise) begin
            hi_cnt_q <= !tms_s ? 3'h0 : (hi_cnt_q == 3'h7 ? hi_cnt_q : hi_cnt_q + 3'h1);
        end
    end

    a_tdo_fall_only: assert property (@(posedge CLK) disable iff (SRST)
        $changed(TDO) |-> $past(tck_fall))
        else $error("TDO changed without a falling test-clock edge");

    a_oe_shift_only: assert property (@(posedge CLK) disable iff (SRST)
        $rose(TDO_OE) |-> (st_q == ST_SHIFT_IR || st_q == ST_SHIFT_DR))
        else $error("TDO enabled outside a shift state");

    a_ir_lsb_out: assert property (@(posedge CLK) disable iff (SRST)
        tck_fall && in_shift_ir |=> TDO == $past(ir_sh_q[0]))
        else $error("Instruction LSB not driven on TDO");

    a_tdi_capture: assert property (@(posedge CLK) disable iff (SRST)
        tck_rise && in_shift_ir |=> ir_sh_q[IR_W-1] == $past(tdi_s))
        else $error("TDI not captured into instruction shift register");

    a_idle_hold: assert property (@(posedge CLK) disable iff (SRST)
        !tck_rise && !tck_fall && st_q != ST_RESET |=> $stable(st_q) && $stable(ir_q))
        else $error("Port state changed without a test-clock edge");

    a_tms_steer: assert property (@(posedge CLK) disable iff (SRST)
        tck_rise && st_q == ST_IDLE |=> st_q == (tms_s ? ST_SEL_DR : ST_IDLE))
        else $error("Wrong state after Run-Test-Idle");

    a_pullup_follow: assert property (@(posedge CLK) disable iff (SRST)
        !$past(SRST) |-> PULLUP_EN == $past(TAP_EN))
        else $error("Pull-up enable does not follow port enable");

    a_oe_off_else: assert property (@(posedge CLK) disable iff (SRST)
        tck_fall && !in_shift_ir && !in_shift_dr |=> !TDO_OE && TDO)
        else $error("TDO still driven after leaving the shift states");

    a_dr_hold: assert property (@(posedge CLK) disable iff (SRST)
        !tck_rise && !tck_fall |=> $stable(dr_sh_q) && $stable(byp_q))
        else $error("Data path changed without a test-clock edge");

    a_byp_capture: assert property (@(posedge CLK) disable iff (SRST)
        tck_rise && st_q == ST_CAP_DR |=> !byp_q)
        else $error("Bypass cell not cleared at Capture-DR");

    a_five_high: assert property (@(posedge CLK) disable iff (SRST)
        hi_cnt_q >= 3'(TLR_HIGH_EDGES) |-> st_q == ST_RESET)
        else $error("Five high mode samples did not reach reset");

    a_reset_stay: assert property (@(posedge CLK) disable iff (SRST)
        tck_rise && st_q == ST_RESET && tms_s |=> st_q == ST_RESET && ir_q == IR_BYPASS)
        else $error("Left Test-Logic-Reset with mode select high");

    a_reset_to_idle: assert property (@(posedge CLK) disable iff (SRST)
        tck_rise && st_q == ST_RESET && !tms_s |=> st_q == ST_IDLE)
        else $error("Low mode sample in reset did not reach idle");

    a_no_shift_else: assert property (@(posedge CLK) disable iff (SRST)
        st_q != ST_CAP_IR && !in_shift_ir |=> $stable(ir_sh_q))
        else $error("Instruction shift register moved outside capture or shift");

    a_capture_ir: assert property (@(posedge CLK) disable iff (SRST)
        tck_rise && st_q == ST_CAP_IR |=> ir_sh_q == IR_CAPTURE)
        else $error("Capture-IR did not load the fixed pattern");

    a_update_ir: assert property (@(posedge CLK) disable iff (SRST)
        $changed(ir_q) |-> $past(st_q) == ST_RESET ||
                           ($past(tck_fall) && $past(st_q) == ST_UPD_IR))
        else $error("Instruction changed outside Update-IR");

    a_bypass_sel: assert property (@(posedge CLK) disable iff (SRST)
        tck_fall && st_q == ST_UPD_IR && ir_sh_q[0] && ir_sh_q != IR_SAMPLE
        |=> sel_q == SEL_BYPASS)
        else $error("Bypass code did not select the bypass cell");

    c_ir_update: cover property (@(posedge CLK) disable iff (SRST)
        tck_fall && st_q == ST_UPD_IR);
    c_dr_push: cover property (@(posedge CLK) disable iff (SRST)
        dr_upd && fill_if.ready);
    c_buf_full: cover property (@(posedge CLK) disable iff (SRST)
        !fill_if.ready && !DR_OUT_READY);
    c_pause_dr: cover property (@(posedge CLK) disable iff (SRST)
        tck_rise && st_q == ST_PAUSE_DR);
    c_five_reset: cover property (@(posedge CLK) disable iff (SRST)
        hi_cnt_q == 3'(TLR_HIGH_EDGES) && $past(st_q) != ST_RESET);
endmodule : jtp_tap

// ### bench/jtp_host_model.sv
// Host adapter model that clocks the test port pins
`timescale 1ns/1ps
module jtp_host_model (
    // Pins driven by the host
    output logic      TCK,
    output logic      TMS,
    output logic      TDI,
    // Pins seen by the host
    input  wire logic TDO,
    input  wire logic TDO_OE,
    input  wire logic PULLUP_EN
);
    // Half period of 62.5 ns keeps the test clock at 8 MHz, below an eighth of 100 MHz
    realtime high_ns  = 62.5;
    realtime low_ns   = 62.5;
    logic    last_drv = 1'b0;
    wire     tdo_line;

    initial begin
        TCK = 1'b0;
        TMS = 1'b1;
        TDI = 1'b1;
    end

    always @(TDO or TDO_OE) begin
        if (TDO_OE === 1'b1)
            last_drv = TDO;
    end

    // A released line floats to the pull-up, otherwise it shows a misleading level
    assign tdo_line = TDO_OE ? TDO : (PULLUP_EN ? 1'b1 : ~last_drv);

    ////////////////////////////////////////////////////////////////////////////////
    // Mode and data change while the clock is low; the output is read at the rise
    task automatic tick(input logic tms, input logic tdi, output logic tdo);
        TMS = tms;
        TDI = tdi;
        #(low_ns);
        TCK = 1'b1;
        tdo = tdo_line;
        #(high_ns);
        TCK = 1'b0;
    endtask : tick
endmodule : jtp_host_model

// ### bench/jtp_tap_tb.sv
// Self-checking bench for the test access port controller
`timescale 1ns/1ps
module jtp_tap_tb
    import jtp_pkg::*;
;
    logic       CLK = 1'b0, SRST = 1'b1, TAP_EN = 1'b0, DR_OUT_READY = 1'b0;
    logic [9:0] DR_IN_DATA = 10'h0;
    logic       TCK, TMS, TDI, TDO, TDO_OE, PULLUP_EN, DR_OUT_VALID, DR_BUF_READY;
    logic [2:0] pib;
    logic [1:0] DR_OUT_SEL;
    logic [9:0] DR_OUT_DATA, prev, q;
    logic [9:0] w [3];
    int         bad_count = 0, tests_run = 0, cycles = 0, seed = 32'h2ca9a10d;
    int         pause_at = -1;

    always #5 CLK = ~CLK;

    jtp_tap #(.DR_W(DEBUG_LEN)) dut (
        .CLK(CLK), .SRST(SRST), .TCK(TCK), .TMS(TMS), .TDI(TDI), .TDO(TDO),
        .TDO_OE(TDO_OE), .TAP_EN(TAP_EN), .PULLUP_EN(PULLUP_EN),
        .PARALLEL_INSTRUCTION_BITS(pib), .DR_OUT_VALID(DR_OUT_VALID),
        .DR_OUT_READY(DR_OUT_READY), .DR_OUT_SEL(DR_OUT_SEL), .DR_OUT_DATA(DR_OUT_DATA),
        .DR_BUF_READY(DR_BUF_READY), .DR_IN_DATA(DR_IN_DATA));

    jtp_host_model host (
        .TCK(TCK), .TMS(TMS), .TDI(TDI), .TDO(TDO), .TDO_OE(TDO_OE), .PULLUP_EN(PULLUP_EN));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up

    function automatic logic [9:0] mask(input int n);
        return 10'((1 << n) - 1);
    endfunction : mask

    // Navigation clocks carry random data that must be ignored
    task automatic step(input logic tms);
        int   r;
        logic d;
        r = $random(seed);
        host.tick(tms, r[0], d);
    endtask : step

    // From Run-Test-Idle through one scan and back to Run-Test-Idle
    task automatic scan(input logic ir, input int n, input logic [9:0] di,
                        output logic [9:0] dq);
        logic b;
        dq = 10'h0;
        step(1'b1);
        if (ir)
            step(1'b1);
        step(1'b0);
        step(1'b0);
        for (int i = 0; i < n; i++) begin
            host.tick(i == n - 1 || i == pause_at, di[i], b);
            dq[i] = b;
            // Detour through Exit1, Pause and Exit2 back into the shift state
            if (i == pause_at && i != n - 1) begin
                step(1'b0);
                step(1'b1);
                step(1'b0);
            end
        end
        step(1'b1);
        step(1'b0);
    endtask : scan

    task automatic load_ir(input logic [2:0] code);
        logic [9:0] cap;
        scan(1'b1, 3, 10'(code), cap);
        check(cap, 10'(IR_CAPTURE));
        check(10'(pib), 10'(code));
        check(10'(TDO_OE), 10'h0);
    endtask : load_ir

    task automatic pop(input logic [9:0] d, input logic [1:0] s);
        check(10'(DR_OUT_VALID), 10'h1);
        check(DR_OUT_DATA, d);
        check(10'(DR_OUT_SEL), 10'(s));
        @(posedge CLK) DR_OUT_READY <= 1'b1;
        @(posedge CLK) DR_OUT_READY <= 1'b0;
        #1;
    endtask : pop

    // Each round shifts a random word in and the previously loaded word out
    task automatic run_dr(input logic [2:0] code, input int n, input logic [1:0] s);
        logic [9:0] din, nxt;
        load_ir(code);
        for (int r = 0; r < 4; r++) begin
            host.low_ns = (r == 2) ? 3000.0 : 62.5;
            pause_at = r - 1;
            din = 10'($random(seed)) & mask(n);
            nxt = 10'($random(seed));
            @(posedge CLK) DR_IN_DATA <= nxt;
            scan(1'b0, n, din, q);
            if (r > 0)
                check(q, prev);
            prev = nxt & mask(n);
            pop(din, s);
        end
        host.low_ns = 62.5;
    endtask : run_dr

    always @(TDO) begin
        if (TDO_OE === 1'b1)
            check(10'(TCK), 10'h0);
    end

    // Limit is well above the expected length of the whole sequence
    always @(posedge CLK) begin
        cycles++;
        if (cycles > 60000) begin
            bad_count++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge CLK);
        SRST <= 1'b0;
        @(posedge CLK) #1;
        check(10'(pib), 10'(IR_BYPASS));
        check(10'({TDO_OE, DR_OUT_VALID, DR_BUF_READY}), 10'h1);
        @(posedge CLK) TAP_EN <= 1'b1;
        @(posedge CLK) #1;
        check(10'(PULLUP_EN), 10'h1);
        @(posedge CLK) TAP_EN <= 1'b0;
        @(posedge CLK) #1;
        check(10'(PULLUP_EN), 10'h0);
        @(posedge CLK) TAP_EN <= 1'b1;
        step(1'b0);
        for (int c = 0; c < 8; c++) begin
            pause_at = c % 3 - 1;
            load_ir(3'(c));
            if (c == 3 || c == 5 || c == 7) begin
                prev = 10'($random(seed)) & mask(4);
                scan(1'b0, 4, prev, q);
                check(q, {prev[8:0], 1'b0} & mask(4));
                check(10'(DR_OUT_VALID), 10'h0);
            end
        end
        run_dr(IR_DEBUG, DEBUG_LEN, 2'(SEL_DEBUG));
        run_dr(IR_PROG, PROG_LEN, 2'(SEL_PROG));
        // Receiver stalls while three words arrive; the third has no room
        load_ir(IR_DEBUG);
        for (int k = 0; k < 3; k++) begin
            w[k] = 10'($random(seed));
            scan(1'b0, DEBUG_LEN, w[k], q);
            if (k == 1)
                check(10'(DR_BUF_READY), 10'h0);
        end
        pop(w[0], 2'(SEL_DEBUG));
        pop(w[1], 2'(SEL_DEBUG));
        check(10'(DR_OUT_VALID), 10'h0);
        repeat (6) step(1'b0);
        check(10'({pib, DR_OUT_VALID}), 10'({IR_DEBUG, 1'b0}));
        step(1'b1);
        step(1'b1);
        check(10'(pib), 10'(IR_DEBUG));
        step(1'b1);
        check(10'(pib), 10'(IR_BYPASS));
        repeat (3) step(1'b1);
        check(10'(pib), 10'(IR_BYPASS));
        step(1'b0);
        load_ir(IR_DEBUG);
        step(1'b1);
        step(1'b0);
        repeat (3) step(1'b0);
        repeat (4) step(1'b1);
        check(10'(pib), 10'(IR_DEBUG));
        step(1'b1);
        check(10'(pib), 10'(IR_BYPASS));
        @(posedge CLK) DR_OUT_READY <= 1'b1;
        step(1'b0);
        load_ir(IR_PROG);
        @(posedge CLK) SRST <= 1'b1;
        repeat (3) @(posedge CLK);
        SRST <= 1'b0;
        @(posedge CLK) #1;
        check(10'({pib, TDO_OE, DR_OUT_VALID}), 10'({IR_BYPASS, 2'b00}));
        wrap_up();
    end
endmodule : jtp_tap_tb
